/* rtl/ifeu_top.sv */
// module: interrupt pending flags, source enables and request output behind an axi4-lite slave
//
// Register access over AXI4-Lite was left to the implementer.
`timescale 1ns/10ps
`default_nettype none
module ifeu_top #(
  parameter int ADDR_W = 8
) (
  input wire logic aclk,
  input wire logic aresetn,
  // axi4-lite slave
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output ifeu_pkg::ifeu_resp_t s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output ifeu_pkg::ifeu_resp_t s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // event sources
  input wire logic converter_done,
  input wire logic second_timer_overflow,
  input wire logic timer_one_overflow,
  input wire logic timer_zero_overflow,
  input wire logic wakeup_timeout,
  input wire logic ext_pin0,
  input wire logic ext_pin1,
  input wire logic ext_pin2,
  input wire logic comparator_match,
  input wire logic pulse_period_rollover,
  input wire logic low_supply_detect,
  // to the core and the wakeup timer
  output logic irq,
  output logic wakeup_timer_run
);
  import ifeu_pkg::*;

  // the decoder always looks at address bits 7:2, so fewer than 8 bits cannot work
  if (ADDR_W < 8 || ADDR_W > 32)
  begin : g_bad_addr
    $error("address width must lie between 8 and 32");
  end

  typedef struct packed {
    logic aw_held;
    logic [ADDR_W-1:0] awaddr;
    logic w_held;
    logic [15:0] wdata;
    logic [1:0] wstrb;
    logic bvalid;
    ifeu_resp_t bresp;
    logic rvalid;
    logic [31:0] rdata;
    ifeu_resp_t rresp;
    logic [7:0] source_enables_primary;
    logic [7:0] pending_flags_primary;
    logic [7:0] source_enables_secondary;
    logic [7:0] pending_flags_secondary;
    logic irq;
  } ifeu_state_t;

  ifeu_state_t st_r;
  ifeu_state_t st_nxt;

  logic [IFEU_NUM_PINS-1:0] pin_rise;
  logic [IFEU_NUM_PINS-1:0] pin_fall;
  logic [7:0] set_pri;
  logic [7:0] set_sec;
  logic wr_go;
  logic aw_take;
  logic w_take;
  logic ar_take;

  // pins pass through two flops before any edge logic sees them
  ifeu_pin_edge #(
    .WIDTH(IFEU_NUM_PINS)
  ) u_pin_edge (
    .aclk(aclk),
    .aresetn(aresetn),
    .pin_in({ext_pin2, ext_pin1, ext_pin0}),
    .rise(pin_rise),
    .fall(pin_fall)
  );

  // hardware set requests, one bit per flag position
  always_comb
  begin
    set_pri = 8'h00;
    set_sec = 8'h00;
    set_pri[IFEU_BIT_CONV] = converter_done;
    set_pri[IFEU_BIT_TMR2] = second_timer_overflow;
    set_pri[IFEU_BIT_TMR1] = timer_one_overflow;
    set_pri[IFEU_BIT_TMR0] = timer_zero_overflow;
    set_pri[IFEU_BIT_WAKE] = wakeup_timeout;
    set_pri[IFEU_BIT_PIN2] = pin_fall[2];
    set_pri[IFEU_BIT_PIN1] = pin_rise[1] | pin_fall[1];
    set_pri[IFEU_BIT_PIN0] = pin_rise[0] | pin_fall[0];
    set_sec[IFEU_BIT_CMP] = comparator_match;
    set_sec[IFEU_BIT_PWM] = pulse_period_rollover;
    // level input: the flag keeps re-arming while the supply stays low
    set_sec[IFEU_BIT_LVD] = low_supply_detect;
  end

  // channel handshakes; one write and one read in flight at most
  assign s_axi_awready = !st_r.aw_held && !st_r.bvalid;
  assign s_axi_wready = !st_r.w_held && !st_r.bvalid;
  assign s_axi_arready = !st_r.rvalid;
  assign aw_take = s_axi_awvalid && s_axi_awready;
  assign w_take = s_axi_wvalid && s_axi_wready;
  assign ar_take = s_axi_arvalid && s_axi_arready;
  assign wr_go = st_r.aw_held && st_r.w_held && !st_r.bvalid;

  // next state: bus capture, register writes, flag update, read data
  always_comb
  begin
    logic [7:0] clr_pri;
    logic [7:0] clr_sec;
    logic [7:0] addr8;
    clr_pri = 8'h00;
    clr_sec = 8'h00;
    addr8 = 8'h00;
    st_nxt = st_r;
    if (aw_take)
    begin
      st_nxt.aw_held = 1'b1;
      st_nxt.awaddr = s_axi_awaddr;
    end
    if (w_take)
    begin
      st_nxt.w_held = 1'b1;
      st_nxt.wdata = s_axi_wdata[15:0];
      st_nxt.wstrb = s_axi_wstrb[1:0];
    end
    if (st_r.bvalid && s_axi_bready)
      st_nxt.bvalid = 1'b0;
    // address and data may arrive in either order; commit once both are held
    if (wr_go)
    begin
      st_nxt.aw_held = 1'b0;
      st_nxt.w_held = 1'b0;
      st_nxt.bvalid = 1'b1;
      st_nxt.bresp = IFEU_RESP_OKAY;
      addr8 = {st_r.awaddr[7:2], 2'b00};
      if (st_r.awaddr[ADDR_W-1:2] != (ADDR_W-2)'(addr8[7:2]))
        st_nxt.bresp = IFEU_RESP_SLVERR;
      else if (addr8 == IFEU_ADDR_EN_PRI)
      begin
        if (st_r.wstrb[0])
          st_nxt.source_enables_primary = st_r.wdata[7:0];
      end
      else if (addr8 == IFEU_ADDR_FLAG_PRI)
      begin
        if (st_r.wstrb[0])
          clr_pri = ~st_r.wdata[7:0];
      end
      else if (addr8 == IFEU_ADDR_EN_SEC)
      begin
        if (st_r.wstrb[0])
          st_nxt.source_enables_secondary = st_r.wdata[7:0] & IFEU_SEC_MASK;
      end
      else if (addr8 == IFEU_ADDR_FLAG_SEC)
      begin
        if (st_r.wstrb[0])
          clr_sec = ~st_r.wdata[7:0] & IFEU_SEC_MASK;
      end
      else if (addr8 == IFEU_ADDR_FLAG_CLR)
      begin
        // write-one-to-clear alias, lets software clear one flag without a read
        if (st_r.wstrb[0])
          clr_pri = st_r.wdata[7:0];
        if (st_r.wstrb[1])
          clr_sec = st_r.wdata[15:8] & IFEU_SEC_MASK;
      end
      else
        st_nxt.bresp = IFEU_RESP_SLVERR;
    end
    // set wins over a clear in the same cycle so no event is lost
    st_nxt.pending_flags_primary = (st_r.pending_flags_primary & ~clr_pri) | set_pri;
    st_nxt.pending_flags_secondary =
      ((st_r.pending_flags_secondary & ~clr_sec) | set_sec) & IFEU_SEC_MASK;
    // read channel
    if (st_r.rvalid && s_axi_rready)
      st_nxt.rvalid = 1'b0;
    if (ar_take)
    begin
      addr8 = {s_axi_araddr[7:2], 2'b00};
      st_nxt.rvalid = 1'b1;
      st_nxt.rresp = IFEU_RESP_OKAY;
      st_nxt.rdata = 32'h0000_0000;
      if (s_axi_araddr[ADDR_W-1:2] != (ADDR_W-2)'(addr8[7:2]))
        st_nxt.rresp = IFEU_RESP_SLVERR;
      else if (addr8 == IFEU_ADDR_EN_PRI)
        st_nxt.rdata[7:0] = st_r.source_enables_primary;
      else if (addr8 == IFEU_ADDR_FLAG_PRI)
        st_nxt.rdata[7:0] = st_r.pending_flags_primary;
      else if (addr8 == IFEU_ADDR_EN_SEC)
        st_nxt.rdata[7:0] = st_r.source_enables_secondary;
      else if (addr8 == IFEU_ADDR_FLAG_SEC)
        st_nxt.rdata[7:0] = st_r.pending_flags_secondary;
      else if (addr8 == IFEU_ADDR_FLAG_CLR)
        st_nxt.rdata = 32'h0000_0000; // write-only, reads zero
      else
        st_nxt.rresp = IFEU_RESP_SLVERR;
    end
    // request is registered from the next flags and enables, so it changes on the same edge as they do
    st_nxt.irq = |((st_nxt.pending_flags_primary & st_nxt.source_enables_primary) |
      (st_nxt.pending_flags_secondary & st_nxt.source_enables_secondary));
  end

  // all state in one register; reset constants only
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      st_r <= '0;
      st_r.source_enables_primary <= IFEU_RST_EN;
      st_r.source_enables_secondary <= IFEU_RST_EN;
      st_r.pending_flags_primary <= IFEU_RST_FLAG;
      st_r.pending_flags_secondary <= IFEU_RST_FLAG;
    end
    else
      st_r <= st_nxt;
  end

  // outputs straight from the state register
  assign s_axi_bvalid = st_r.bvalid;
  assign s_axi_bresp = st_r.bresp;
  assign s_axi_rvalid = st_r.rvalid;
  assign s_axi_rdata = st_r.rdata;
  assign s_axi_rresp = st_r.rresp;
  assign irq = st_r.irq;
  assign wakeup_timer_run = st_r.source_enables_primary[IFEU_BIT_WAKE];

  // checks on flags, enables and the request
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  enables_reset_a:
    assert property (disable iff (1'b0) !aresetn |=> (st_r.source_enables_primary == 8'h00 &&
      st_r.source_enables_secondary == 8'h00))
    else $error("enables not zero after reset");

  conv_flag_set_a:
    assert property (converter_done |=> st_r.pending_flags_primary[IFEU_BIT_CONV])
    else $error("converter done did not set its flag");

  flag_clear_a:
    assert property (wr_go && st_r.awaddr == ADDR_W'(IFEU_ADDR_FLAG_PRI) && st_r.wstrb[0] &&
      st_r.wdata[IFEU_BIT_TMR0] == 1'b0 && !timer_zero_overflow
      |=> !st_r.pending_flags_primary[IFEU_BIT_TMR0])
    else $error("writing zero did not clear the flag");

  flag_keep_a:
    assert property (wr_go && st_r.awaddr == ADDR_W'(IFEU_ADDR_FLAG_SEC) && st_r.wstrb[0] &&
      st_r.wdata[IFEU_BIT_CMP] && st_r.pending_flags_secondary[IFEU_BIT_CMP]
      |=> st_r.pending_flags_secondary[IFEU_BIT_CMP])
    else $error("writing one changed the flag");

  tmr2_flag_set_a:
    assert property (second_timer_overflow |=> st_r.pending_flags_primary[IFEU_BIT_TMR2])
    else $error("second timer overflow lost");

  tmr1_flag_set_a:
    assert property (timer_one_overflow |=> st_r.pending_flags_primary[IFEU_BIT_TMR1])
    else $error("timer one overflow lost");

  tmr0_flag_set_a:
    assert property (timer_zero_overflow |=> st_r.pending_flags_primary[IFEU_BIT_TMR0])
    else $error("timer zero overflow lost");

  wake_flag_set_a:
    assert property (wakeup_timeout |=> st_r.pending_flags_primary[IFEU_BIT_WAKE])
    else $error("wakeup timeout lost");

  pin2_fall_only_a:
    assert property ($fell(ext_pin2) ##1 1'b1 |=> ##1 st_r.pending_flags_primary[IFEU_BIT_PIN2])
    else $error("pin 2 falling edge did not set its flag");

  pin2_rise_quiet_a:
    assert property (!st_r.pending_flags_primary[IFEU_BIT_PIN2] && pin_rise[2]
      |=> !st_r.pending_flags_primary[IFEU_BIT_PIN2])
    else $error("pin 2 rising edge set its flag");

  pin1_edge_a:
    assert property (ext_pin1 != $past(ext_pin1) |-> ##3 st_r.pending_flags_primary[IFEU_BIT_PIN1])
    else $error("pin 1 edge did not set its flag");

  pin0_edge_a:
    assert property (ext_pin0 != $past(ext_pin0) |-> ##3 st_r.pending_flags_primary[IFEU_BIT_PIN0])
    else $error("pin 0 edge did not set its flag");

  sec_reserved_a:
    assert property (((st_r.source_enables_secondary | st_r.pending_flags_secondary) &
      ~IFEU_SEC_MASK) == 8'h00)
    else $error("reserved secondary bit set");

  cmp_flag_set_a:
    assert property (comparator_match |=> st_r.pending_flags_secondary[IFEU_BIT_CMP])
    else $error("comparator match lost");

  pwm_flag_set_a:
    assert property (pulse_period_rollover |=> st_r.pending_flags_secondary[IFEU_BIT_PWM])
    else $error("period roll-over lost");

  lvd_hold_a:
    assert property (low_supply_detect [*2] |=> st_r.pending_flags_secondary[IFEU_BIT_LVD])
    else $error("low supply flag not held");

  wake_run_a:
    assert property (wr_go && st_r.awaddr == ADDR_W'(IFEU_ADDR_EN_PRI) && st_r.wstrb[0]
      |=> wakeup_timer_run == $past(st_r.wdata[IFEU_BIT_WAKE]))
    else $error("wakeup run does not follow its enable write");

  conv_no_set_a:
    assert property (!st_r.pending_flags_primary[IFEU_BIT_CONV] && !converter_done
      |=> !st_r.pending_flags_primary[IFEU_BIT_CONV])
    else $error("converter flag set without an event");

  lvd_no_set_a:
    assert property (!st_r.pending_flags_secondary[IFEU_BIT_LVD] && !low_supply_detect
      |=> !st_r.pending_flags_secondary[IFEU_BIT_LVD])
    else $error("low supply flag set while supply is fine");

  en_pri_stable_a:
    assert property (!wr_go |=> $stable(st_r.source_enables_primary))
    else $error("primary enables changed without a write");

  en_sec_stable_a:
    assert property (!wr_go |=> $stable(st_r.source_enables_secondary))
    else $error("secondary enables changed without a write");

  irq_level_a:
    assert property (##1 irq == |((st_r.pending_flags_primary & st_r.source_enables_primary) |
      (st_r.pending_flags_secondary & st_r.source_enables_secondary)))
    else $error("request does not match enabled flags");

  irq_drop_a:
    assert property ($fell(irq) |-> $past(wr_go) || !$past(aresetn))
    else $error("request fell without a register write");

endmodule
`default_nettype wire

/* rtl/ifeu_pkg.sv */
// package: register map, field positions and reset values of the interrupt flag/enable unit
// Contract
// - pin 0 enable is primary enable bit 0
// - converter done sets primary flag bit 7
// - writing zero clears a flag, one keeps
// - second timer overflow sets primary bit 6
// - timer one overflow sets primary bit 5
// - timer zero overflow sets primary bit 4
// - wakeup timeout sets primary flag bit 3
// - pin 2 falling edge sets bit 2
// - pin 1 either edge sets bit 1
// - pin 0 either edge sets bit 0
// - secondary enables at bits 4, 1, 0
// - comparator match sets secondary flag bit 4
// - period roll-over sets secondary flag bit 1
// - low supply sets secondary flag bit 0
// - primary enables reset zero; bit 3 runs wakeup
package ifeu_pkg;

  // register indices as printed; byte address is four times the index
  localparam logic [5:0] IFEU_IDX_EN_PRI = 6'h0b;
  localparam logic [5:0] IFEU_IDX_FLAG_PRI = 6'h0c;
  localparam logic [5:0] IFEU_IDX_EN_SEC = 6'h0d;
  localparam logic [5:0] IFEU_IDX_FLAG_SEC = 6'h0e;
  localparam logic [5:0] IFEU_IDX_FLAG_CLR = 6'h10;

  localparam logic [7:0] IFEU_ADDR_EN_PRI = {IFEU_IDX_EN_PRI, 2'b00};
  localparam logic [7:0] IFEU_ADDR_FLAG_PRI = {IFEU_IDX_FLAG_PRI, 2'b00};
  localparam logic [7:0] IFEU_ADDR_EN_SEC = {IFEU_IDX_EN_SEC, 2'b00};
  localparam logic [7:0] IFEU_ADDR_FLAG_SEC = {IFEU_IDX_FLAG_SEC, 2'b00};
  localparam logic [7:0] IFEU_ADDR_FLAG_CLR = {IFEU_IDX_FLAG_CLR, 2'b00};

  // primary register bit positions (flags and enables share them)
  localparam int IFEU_BIT_CONV = 7;
  localparam int IFEU_BIT_TMR2 = 6;
  localparam int IFEU_BIT_TMR1 = 5;
  localparam int IFEU_BIT_TMR0 = 4;
  localparam int IFEU_BIT_WAKE = 3;
  localparam int IFEU_BIT_PIN2 = 2;
  localparam int IFEU_BIT_PIN1 = 1;
  localparam int IFEU_BIT_PIN0 = 0;

  // secondary register bit positions
  localparam int IFEU_BIT_CMP = 4;
  localparam int IFEU_BIT_PWM = 1;
  localparam int IFEU_BIT_LVD = 0;
  localparam logic [7:0] IFEU_SEC_MASK = 8'h13;

  // values after reset
  localparam logic [7:0] IFEU_RST_EN = 8'h00;
  localparam logic [7:0] IFEU_RST_FLAG = 8'h00;

  // number of external pins watched for edges
  localparam int IFEU_NUM_PINS = 3;

  // axi response codes
  typedef logic [1:0] ifeu_resp_t;
  localparam ifeu_resp_t IFEU_RESP_OKAY = 2'b00;
  localparam ifeu_resp_t IFEU_RESP_SLVERR = 2'b10;

endpackage

/* rtl/ifeu_pin_edge.sv */
// module: synchroniser and edge detector for the external interrupt pins
`timescale 1ns/10ps
`default_nettype none
module ifeu_pin_edge #(
  parameter int WIDTH = 3
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [WIDTH-1:0] pin_in,
  output logic [WIDTH-1:0] rise,
  output logic [WIDTH-1:0] fall
);
  import ifeu_pkg::*;

  typedef struct packed {
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] sync;
    logic [WIDTH-1:0] last;
  } ifeu_edge_state_t;

  ifeu_edge_state_t st_r;
  ifeu_edge_state_t st_nxt;

  if (WIDTH < 1)
  begin : g_bad_width
    $error("pin count must be at least one");
  end

  // meta feeds only sync; edges are taken between sync and last
  always_comb
  begin
    st_nxt = st_r;
    st_nxt.meta = pin_in;
    st_nxt.sync = st_r.meta;
    st_nxt.last = st_r.sync;
  end

  // reset level low so a pin held high at release reports one rise
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      st_r <= '0;
    else
      st_r <= st_nxt;
  end

  // one-cycle pulses per pin
  for (genvar i = 0; i < WIDTH; i++)
  begin : g_edge
    assign rise[i] = st_r.sync[i] & ~st_r.last[i];
    assign fall[i] = ~st_r.sync[i] & st_r.last[i];
  end

endmodule
`default_nettype wire

/* verif/ifeu_src_model.sv */
// event sources and pins that stand around the flag unit, driven from the bench
`timescale 1ns/10ps
`default_nettype none
module ifeu_src_model (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [6:0] pulse_req,
  input wire logic low_level,
  input wire logic [2:0] pin_lvl,
  output logic converter_done,
  output logic second_timer_overflow,
  output logic timer_one_overflow,
  output logic timer_zero_overflow,
  output logic wakeup_timeout,
  output logic comparator_match,
  output logic pulse_period_rollover,
  output logic low_supply_detect,
  output logic [2:0] pins
);
  // one-cycle event strobes; a peripheral never holds an overflow high longer
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      {converter_done, second_timer_overflow, timer_one_overflow} <= 3'h0;
      {timer_zero_overflow, wakeup_timeout, comparator_match} <= 3'h0;
      {pulse_period_rollover, low_supply_detect, pins} <= 5'h00;
    end
    else
    begin
      // request bit i drives the source listed i-th in the bench tables
      converter_done <= pulse_req[0];
      second_timer_overflow <= pulse_req[1];
      timer_one_overflow <= pulse_req[2];
      timer_zero_overflow <= pulse_req[3];
      wakeup_timeout <= pulse_req[4];
      comparator_match <= pulse_req[5];
      pulse_period_rollover <= pulse_req[6];
      low_supply_detect <= low_level; // level, stays while supply is low
      pins <= pin_lvl; // pins are asynchronous to the unit, it must resync
    end
  end
endmodule
`default_nettype wire

/* verif/tb.sv */
// self-checking bench for the interrupt flag/enable unit over axi4-lite
`timescale 1ns/10ps
`default_nettype none
module tb;
  import ifeu_pkg::*;
  logic aclk, aresetn;
  logic [7:0] awaddr, araddr;
  logic awvalid, wvalid, bready, arvalid, rready;
  logic awready, wready, bvalid, arready, rvalid, irq, wake_run, low_level;
  logic [31:0] wdata, rdata;
  ifeu_resp_t bresp, rresp;
  logic [6:0] pulse_req;
  logic [2:0] pin_lvl, pins;
  logic ev_conv, ev_t2, ev_t1, ev_t0, ev_wk, ev_cmp, ev_pwm, ev_lvd;
  int bad_count, num_checks;

  ifeu_top dut_u (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .converter_done(ev_conv), .second_timer_overflow(ev_t2), .timer_one_overflow(ev_t1),
    .timer_zero_overflow(ev_t0), .wakeup_timeout(ev_wk), .ext_pin0(pins[0]),
    .ext_pin1(pins[1]), .ext_pin2(pins[2]), .comparator_match(ev_cmp),
    .pulse_period_rollover(ev_pwm), .low_supply_detect(ev_lvd), .irq(irq),
    .wakeup_timer_run(wake_run));

  ifeu_src_model src_u (.aclk(aclk), .aresetn(aresetn), .pulse_req(pulse_req),
    .low_level(low_level), .pin_lvl(pin_lvl), .converter_done(ev_conv),
    .second_timer_overflow(ev_t2), .timer_one_overflow(ev_t1), .timer_zero_overflow(ev_t0),
    .wakeup_timeout(ev_wk), .comparator_match(ev_cmp), .pulse_period_rollover(ev_pwm),
    .low_supply_detect(ev_lvd), .pins(pins));

  // 200 mhz clock
  initial
  begin
    aclk = 1'b0;
    forever #2.5 aclk = ~aclk;
  end

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  task automatic chk_val(input string what, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp)
    begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic chk_bit(input string what, input logic exp, input logic got);
    chk_val(what, {31'h0, exp}, {31'h0, got});
  endtask

  task automatic chk_resp(input string what, input ifeu_resp_t exp, input ifeu_resp_t got);
    chk_val(what, {30'h0, exp}, {30'h0, got});
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge aclk);
  endtask

  // readiness only moves at rising edges, so it is sampled safely mid-cycle
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output ifeu_resp_t r);
    int n;
    logic aw_hs, w_hs, b_hs;
    n = 0;
    b_hs = 1'b0;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!b_hs)
    begin
      @(negedge aclk);
      aw_hs = awvalid && awready;
      w_hs = wvalid && wready;
      b_hs = bvalid;
      r = bresp;
      @(posedge aclk);
      if (aw_hs) awvalid <= 1'b0;
      if (w_hs) wvalid <= 1'b0;
      if (b_hs) bready <= 1'b0;
      n++;
      if (n > 50)
      begin
        bad_count++;
        give_verdict();
      end
    end
  endtask

  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output ifeu_resp_t r);
    int n;
    logic ar_hs, r_hs;
    n = 0;
    r_hs = 1'b0;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    while (!r_hs)
    begin
      @(negedge aclk);
      ar_hs = arvalid && arready;
      r_hs = rvalid;
      d = rdata;
      r = rresp;
      @(posedge aclk);
      if (ar_hs) arvalid <= 1'b0;
      if (r_hs) rready <= 1'b0;
      n++;
      if (n > 50)
      begin
        bad_count++;
        give_verdict();
      end
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    ifeu_resp_t r;
    axi_wr(a, d, r);
    chk_resp("write resp", IFEU_RESP_OKAY, r);
  endtask

  task automatic rd_chk(input string what, input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] d;
    ifeu_resp_t r;
    axi_rd(a, d, r);
    chk_val(what, exp, d);
  endtask

  // after reset, then enable read-back with the reserved secondary bits
  task automatic sc_enables();
    rd_chk("en pri rst", IFEU_ADDR_EN_PRI, 32'h0000_0000);
    rd_chk("en sec rst", IFEU_ADDR_EN_SEC, 32'h0000_0000);
    rd_chk("fl pri rst", IFEU_ADDR_FLAG_PRI, 32'h0000_0000);
    chk_bit("wake run rst", 1'b0, wake_run);
    wr(IFEU_ADDR_EN_PRI, 32'h0000_00ff);
    rd_chk("en pri rw", IFEU_ADDR_EN_PRI, 32'h0000_00ff);
    chk_bit("wake run on", 1'b1, wake_run);
    wr(IFEU_ADDR_EN_SEC, 32'h0000_00ff);
    rd_chk("en sec rw", IFEU_ADDR_EN_SEC, 32'h0000_0013);
    wr(IFEU_ADDR_EN_PRI, 32'h0000_0000);
    wr(IFEU_ADDR_EN_SEC, 32'h0000_0000);
    chk_bit("wake run off", 1'b0, wake_run);
  endtask

  // each strobed source, then write-one keeps and write-zero clears
  task automatic sc_events();
    int bits[7];
    logic [7:0] a;
    logic [31:0] m;
    bits = '{IFEU_BIT_CONV, IFEU_BIT_TMR2, IFEU_BIT_TMR1, IFEU_BIT_TMR0, IFEU_BIT_WAKE,
      IFEU_BIT_CMP, IFEU_BIT_PWM};
    for (int i = 0; i < 7; i++)
    begin
      a = (i < 5) ? IFEU_ADDR_FLAG_PRI : IFEU_ADDR_FLAG_SEC;
      m = 32'h1 << bits[i];
      @(posedge aclk);
      pulse_req <= 7'h1 << i;
      @(posedge aclk);
      pulse_req <= 7'h00;
      cyc(3);
      rd_chk("flag set", a, m);
      wr(a, 32'h0000_00ff);
      rd_chk("flag kept", a, m);
      wr(a, ~m);
      rd_chk("flag cleared", a, 32'h0000_0000);
    end
  endtask

  // request follows flag and enable; the clear register drops it
  task automatic sc_irq();
    @(posedge aclk);
    pulse_req <= 7'h28;
    @(posedge aclk);
    pulse_req <= 7'h00;
    cyc(4);
    chk_bit("irq masked", 1'b0, irq);
    rd_chk("cmp before clr", IFEU_ADDR_FLAG_SEC, 32'h0000_0010);
    wr(IFEU_ADDR_EN_PRI, 32'h0000_0010);
    cyc(3);
    chk_bit("irq raised", 1'b1, irq);
    wr(IFEU_ADDR_FLAG_CLR, 32'h0000_1010);
    cyc(3);
    chk_bit("irq cleared", 1'b0, irq);
    rd_chk("clr reg read", IFEU_ADDR_FLAG_CLR, 32'h0000_0000);
    rd_chk("flag after clr", IFEU_ADDR_FLAG_PRI, 32'h0000_0000);
    rd_chk("sec after clr", IFEU_ADDR_FLAG_SEC, 32'h0000_0000);
    wr(IFEU_ADDR_EN_PRI, 32'h0000_0000);
  endtask

  // a reset in mid-run drops enables, flags and the request
  task automatic sc_mid_reset();
    wr(IFEU_ADDR_EN_PRI, 32'h0000_0018);
    @(posedge aclk);
    pulse_req <= 7'h08;
    @(posedge aclk);
    pulse_req <= 7'h00;
    cyc(3);
    chk_bit("irq before rst", 1'b1, irq);
    chk_bit("wake run before rst", 1'b1, wake_run);
    aresetn <= 1'b0;
    cyc(2);
    aresetn <= 1'b1;
    cyc(2);
    chk_bit("irq after rst", 1'b0, irq);
    chk_bit("wake run after rst", 1'b0, wake_run);
    rd_chk("en pri mid rst", IFEU_ADDR_EN_PRI, 32'h0000_0000);
    rd_chk("fl pri mid rst", IFEU_ADDR_FLAG_PRI, 32'h0000_0000);
  endtask

  // pin edges: pins 0 and 1 both ways, pin 2 falling only
  task automatic sc_pins();
    logic [2:0] lv[6];
    logic [31:0] ex[6];
    lv = '{3'b001, 3'b000, 3'b010, 3'b000, 3'b100, 3'b000};
    ex = '{32'h01, 32'h01, 32'h02, 32'h02, 32'h00, 32'h04};
    for (int i = 0; i < 6; i++)
    begin
      @(posedge aclk);
      pin_lvl <= lv[i];
      cyc(6);
      rd_chk("pin flag", IFEU_ADDR_FLAG_PRI, ex[i]);
      wr(IFEU_ADDR_FLAG_PRI, 32'h0000_0000);
    end
  endtask

  // a held low supply beats every clear; unmapped places answer with an error
  task automatic sc_lvd_unmapped();
    logic [31:0] d;
    ifeu_resp_t r;
    @(posedge aclk);
    low_level <= 1'b1;
    cyc(3);
    wr(IFEU_ADDR_FLAG_SEC, 32'h0000_0000);
    rd_chk("lvd held", IFEU_ADDR_FLAG_SEC, 32'h0000_0001);
    low_level <= 1'b0;
    cyc(3);
    wr(IFEU_ADDR_FLAG_SEC, 32'h0000_0000);
    rd_chk("lvd gone", IFEU_ADDR_FLAG_SEC, 32'h0000_0000);
    axi_wr(8'h3c, 32'h0000_00ff, r);
    chk_resp("unmapped wr", IFEU_RESP_SLVERR, r);
    axi_rd(8'h3c, d, r);
    chk_resp("unmapped rd", IFEU_RESP_SLVERR, r);
    chk_val("unmapped data", 32'h0000_0000, d);
  endtask

  initial
  begin
    bad_count = 0;
    num_checks = 0;
    aresetn = 1'b0;
    {awvalid, wvalid, bready, arvalid, rready, low_level} = 6'h00;
    {awaddr, araddr, wdata} = 48'h0;
    pulse_req = 7'h00;
    pin_lvl = 3'b000;
    cyc(4);
    aresetn <= 1'b1;
    cyc(2);
    sc_enables();
    sc_events();
    sc_irq();
    sc_pins();
    sc_lvd_unmapped();
    sc_mid_reset();
    give_verdict();
  end
endmodule
`default_nettype wire
